// [hw/csl_pkg.sv]
// Constants, register map and state type for the controller status LED block.
package csl_pkg;

    // ********************************************************************
    // Clock and flash timing
    // ********************************************************************
    localparam int CLK_PERIOD_NS = 20;
    localparam int TICK_PERIOD_NS = 50_000_000;
    localparam int TICK_CYCLES = TICK_PERIOD_NS / CLK_PERIOD_NS;
    localparam logic [4:0] PHASE_LAST = 5'h13;
    localparam logic [4:0] FLASH_PERIOD = 5'h0A;
    localparam logic [4:0] FLASH_ON = 5'h05;
    localparam logic [4:0] SINGLE_ON = 5'h02;
    localparam logic [4:0] TRIPLE_SPAN = 5'h0C;
    localparam int TRIPLE_BIT = 1;

    // ********************************************************************
    // Register map
    // ********************************************************************
    localparam int ADDR_W = 4;
    localparam logic [3:0] OFF_CTRL = 4'h0;
    localparam logic [3:0] OFF_CMD = 4'h4;
    localparam logic [3:0] OFF_STATUS = 4'h8;
    localparam int CTRL_U0_GREEN = 0;
    localparam int CTRL_U0_RED = 1;
    localparam int CTRL_U1_GREEN = 2;
    localparam int CTRL_U1_RED = 3;
    localparam int CTRL_IDENT = 4;
    localparam int CTRL_W = 5;
    localparam logic [4:0] CTRL_RESET = 5'h00;
    localparam int CMD_RUN = 0;
    localparam int CMD_STOP = 1;
    localparam int CMD_RESTART = 2;
    localparam int STAT_STATE_LSB = 0;
    localparam int STAT_COMM_LSB = 4;
    localparam int STAT_EXEC_LSB = 6;
    localparam int STAT_BATT = 8;
    localparam int STAT_PWR_LSB = 9;
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    // ********************************************************************
    // Permission codes and controller states
    // ********************************************************************
    localparam logic [1:0] PERM_NO = 2'h0;
    localparam logic [1:0] PERM_RESTRICTED = 2'h1;
    localparam logic [1:0] PERM_YES = 2'h2;

    typedef enum logic [3:0] {
        ST_BOOT,
        ST_BAD_FW,
        ST_EMPTY,
        ST_RUN,
        ST_STOP,
        ST_HALT,
        ST_REBOOT,
        ST_SYS_HALT
    } csl_state_t;

endpackage : csl_pkg

// [hw/csl_sync.sv]
// Two-flop synchroniser for level inputs arriving from pins.
module csl_sync #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);

    logic [WIDTH-1:0] meta_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            meta_q <= '0;
            sync_out <= '0;
        end
        else
        begin
            meta_q <= async_in;
            sync_out <= meta_q;
        end
    end

endmodule : csl_sync

// [hw/csl_flash_gen.sv]
// Tick divider and repeating flash pattern generator.
module csl_flash_gen #(
    parameter int TICK_CYCLES = csl_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    output logic flash_q,
    output logic single_q,
    output logic triple_q,
    output logic rapid_q
);

    logic [31:0] div_q;
    logic [4:0] phase_q;
    logic [4:0] mod_phase;
    wire tick = (div_q == 32'(TICK_CYCLES - 1));

    // ********************************************************************
    // One frame is twenty ticks; single and triple repeat once per frame, flash twice per frame, rapid every two ticks.
    // ********************************************************************
    assign mod_phase = (phase_q >= csl_pkg::FLASH_PERIOD) ?
        5'(phase_q - csl_pkg::FLASH_PERIOD) : phase_q;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            div_q <= 32'h0;
            phase_q <= 5'h00;
        end
        else
        begin
            div_q <= tick ? 32'h0 : div_q + 32'h1;
            if (tick)
            begin
                phase_q <= (phase_q == csl_pkg::PHASE_LAST) ? 5'h00 : phase_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            flash_q <= 1'b0;
            single_q <= 1'b0;
            triple_q <= 1'b0;
            rapid_q <= 1'b0;
        end
        else
        begin
            flash_q <= mod_phase < csl_pkg::FLASH_ON;
            single_q <= phase_q < csl_pkg::SINGLE_ON;
            triple_q <= (phase_q < csl_pkg::TRIPLE_SPAN) && !phase_q[csl_pkg::TRIPLE_BIT];
            rapid_q <= phase_q[0];
        end
    end

endmodule : csl_flash_gen

// [hw/csl_top.sv]
// Controller status LED block: state tracking, LED patterns and AXI4-Lite registers.
//
// Summary of operation
// - While booting the status LED alternates green and red, with no communication or execution.
// - Leaving boot, firmware and application validity are checked to pick the next state.
// - Invalid firmware flashes red, restricts communication and forbids execution.
// - Bad application or hardware fault gives the empty state: single green flash, talk, no run.
// - Running without a breakpoint or an external or boot-project fault holds the status LED steady green with communication and execution allowed.
// - A stopped valid application flashes green, restricts communication, does not execute.
// - An application error stops execution, enters halt and shows a single red flash.
// - Rebooting after a hardware fault flashes red rapidly, allows talk, does not execute.
// - Halt after a system error shows steady red and blocks communication and execution.
// - Running with an external or boot-project fault shows green with a single red flash.
// - Stopped with an external fault shows flashing green with a single red flash.
// - Outside identification the battery LED is red exactly while the clock battery needs replacement.
// - The two application LEDs follow only the values written by the user application.
// - An identification request flashes the status LED and the battery LED.
// - Each of the three supply inputs lights its own green LED while present.
//
// The AXI4-Lite slave port and the address map are this design's own decisions.
module csl_top #(
    parameter int TICK_CYCLES = csl_pkg::TICK_CYCLES
) (
    input wire logic clk,
    input wire logic rst_b,
    input wire logic boot_done,
    input wire logic fw_valid,
    input wire logic app_valid,
    input wire logic hw_error,
    input wire logic app_error,
    input wire logic sys_error,
    input wire logic ext_error,
    input wire logic boot_proj_bad,
    input wire logic breakpoint_set,
    input wire logic battery_low,
    input wire logic power_main,
    input wire logic power_expert,
    input wire logic power_io,
    input wire logic s_axi_awvalid,
    output logic s_axi_awready,
    input wire logic [3:0] s_axi_awaddr,
    input wire logic s_axi_wvalid,
    output logic s_axi_wready,
    input wire logic [31:0] s_axi_wdata,
    input wire logic [3:0] s_axi_wstrb,
    output logic s_axi_bvalid,
    input wire logic s_axi_bready,
    output logic [1:0] s_axi_bresp,
    input wire logic s_axi_arvalid,
    output logic s_axi_arready,
    input wire logic [3:0] s_axi_araddr,
    output logic s_axi_rvalid,
    input wire logic s_axi_rready,
    output logic [31:0] s_axi_rdata,
    output logic [1:0] s_axi_rresp,
    output logic module_status_led_green,
    output logic module_status_led_red,
    output logic battery_led_red,
    output logic user_led_zero_green,
    output logic user_led_zero_red,
    output logic user_led_one_green,
    output logic user_led_one_red,
    output logic power_main_led,
    output logic power_expert_led,
    output logic power_io_led,
    output logic [1:0] comm_perm,
    output logic [1:0] exec_perm
);

    // ********************************************************************
    // Pin synchronisers and pattern source
    // ********************************************************************
    logic [3:0] pins_s;
    logic flash, single, triple, rapid;

    csl_sync #(.WIDTH(4)) u_sync (
        .clk(clk),
        .rst_b(rst_b),
        .async_in({power_io, power_expert, power_main, battery_low}),
        .sync_out(pins_s)
    );

    csl_flash_gen #(.TICK_CYCLES(TICK_CYCLES)) u_flash (
        .clk(clk),
        .rst_b(rst_b),
        .flash_q(flash),
        .single_q(single),
        .triple_q(triple),
        .rapid_q(rapid)
    );

    // ********************************************************************
    // AXI4-Lite slave
    // ********************************************************************
    logic aw_full_q, w_full_q;
    logic [3:0] aw_addr_q;
    logic [31:0] w_data_q;
    logic [3:0] w_strb_q;
    logic [4:0] ctrl_q;
    csl_pkg::csl_state_t st_q, st_d;

    wire aw_take = s_axi_awvalid && s_axi_awready;
    wire w_take = s_axi_wvalid && s_axi_wready;
    wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
    wire wr_ctrl = do_write && (aw_addr_q == csl_pkg::OFF_CTRL) && w_strb_q[0];
    wire wr_cmd = do_write && (aw_addr_q == csl_pkg::OFF_CMD) && w_strb_q[0];
    wire wr_known = (aw_addr_q == csl_pkg::OFF_CTRL) || (aw_addr_q == csl_pkg::OFF_CMD);
    wire cmd_run = wr_cmd && w_data_q[csl_pkg::CMD_RUN];
    wire cmd_stop = wr_cmd && w_data_q[csl_pkg::CMD_STOP];
    wire cmd_restart = wr_cmd && w_data_q[csl_pkg::CMD_RESTART];
    wire ar_take = s_axi_arvalid && s_axi_arready;
    wire [31:0] status_word = {20'h0, pins_s[3:1], pins_s[0], exec_perm, comm_perm, st_q};
    wire rd_known = (s_axi_araddr == csl_pkg::OFF_CTRL) || (s_axi_araddr == csl_pkg::OFF_STATUS);
    wire [31:0] rd_word = (s_axi_araddr == csl_pkg::OFF_CTRL) ? {27'h0, ctrl_q} :
        (s_axi_araddr == csl_pkg::OFF_STATUS) ? status_word : 32'h0;

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            aw_full_q <= 1'b0;
            w_full_q <= 1'b0;
            aw_addr_q <= 4'h0;
            w_data_q <= 32'h0;
            w_strb_q <= 4'h0;
            s_axi_awready <= 1'b1;
            s_axi_wready <= 1'b1;
            s_axi_bvalid <= 1'b0;
            s_axi_bresp <= csl_pkg::RESP_OKAY;
        end
        else
        begin
            if (aw_take)
            begin
                aw_full_q <= 1'b1;
                aw_addr_q <= s_axi_awaddr;
                s_axi_awready <= 1'b0;
            end
            if (w_take)
            begin
                w_full_q <= 1'b1;
                w_data_q <= s_axi_wdata;
                w_strb_q <= s_axi_wstrb;
                s_axi_wready <= 1'b0;
            end
            if (do_write)
            begin
                s_axi_bvalid <= 1'b1;
                s_axi_bresp <= wr_known ? csl_pkg::RESP_OKAY : csl_pkg::RESP_SLVERR;
            end
            else if (s_axi_bvalid && s_axi_bready)
            begin
                s_axi_bvalid <= 1'b0;
                aw_full_q <= 1'b0;
                w_full_q <= 1'b0;
                s_axi_awready <= 1'b1;
                s_axi_wready <= 1'b1;
            end
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            s_axi_arready <= 1'b1;
            s_axi_rvalid <= 1'b0;
            s_axi_rdata <= 32'h0;
            s_axi_rresp <= csl_pkg::RESP_OKAY;
        end
        else if (ar_take)
        begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_known ? csl_pkg::RESP_OKAY : csl_pkg::RESP_SLVERR;
        end
        else if (s_axi_rvalid && s_axi_rready)
        begin
            s_axi_rvalid <= 1'b0;
            s_axi_arready <= 1'b1;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            ctrl_q <= csl_pkg::CTRL_RESET;
        end
        else if (wr_ctrl)
        begin
            ctrl_q <= w_data_q[csl_pkg::CTRL_W-1:0];
        end
    end

    // ********************************************************************
    // Controller state
    // ********************************************************************
    always_comb
    begin
        st_d = st_q;
        case (st_q)
            csl_pkg::ST_BOOT:
            begin
                if (boot_done)
                begin
                    if (!fw_valid)
                        st_d = csl_pkg::ST_BAD_FW;
                    else if (!app_valid || hw_error)
                        st_d = csl_pkg::ST_EMPTY;
                    else
                        st_d = csl_pkg::ST_STOP;
                end
            end
            csl_pkg::ST_RUN:
            begin
                if (sys_error)
                    st_d = csl_pkg::ST_SYS_HALT;
                else if (hw_error)
                    st_d = csl_pkg::ST_REBOOT;
                else if (app_error)
                    st_d = csl_pkg::ST_HALT;
                else if (cmd_stop)
                    st_d = csl_pkg::ST_STOP;
            end
            csl_pkg::ST_STOP:
            begin
                if (sys_error)
                    st_d = csl_pkg::ST_SYS_HALT;
                else if (hw_error)
                    st_d = csl_pkg::ST_REBOOT;
                else if (cmd_run)
                    st_d = csl_pkg::ST_RUN;
            end
            csl_pkg::ST_HALT:
            begin
                if (sys_error)
                    st_d = csl_pkg::ST_SYS_HALT;
                else if (cmd_restart)
                    st_d = csl_pkg::ST_BOOT;
                else if (cmd_stop)
                    st_d = csl_pkg::ST_STOP;
            end
            csl_pkg::ST_BAD_FW, csl_pkg::ST_EMPTY, csl_pkg::ST_REBOOT, csl_pkg::ST_SYS_HALT:
            begin
                if (cmd_restart)
                    st_d = csl_pkg::ST_BOOT;
            end
            default:
                st_d = csl_pkg::ST_BOOT;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
            st_q <= csl_pkg::ST_BOOT;
        else
            st_q <= st_d;
    end

    // ********************************************************************
    // Status LED colour and permissions
    // ********************************************************************
    // Green is dropped while the red flash shows, since one bicolour LED cannot show both.
    logic msl_g, msl_r;
    logic [1:0] comm_d, exec_d;
    wire ext_fault = ext_error || boot_proj_bad;
    wire ident = ctrl_q[csl_pkg::CTRL_IDENT];

    always_comb
    begin
        msl_g = 1'b0;
        msl_r = 1'b0;
        comm_d = csl_pkg::PERM_YES;
        exec_d = csl_pkg::PERM_NO;
        case (st_q)
            csl_pkg::ST_BOOT:
            begin
                msl_g = flash;
                msl_r = !flash;
                comm_d = csl_pkg::PERM_NO;
            end
            csl_pkg::ST_BAD_FW:
            begin
                msl_r = flash;
                comm_d = csl_pkg::PERM_RESTRICTED;
            end
            csl_pkg::ST_EMPTY:
                msl_g = single;
            csl_pkg::ST_RUN:
            begin
                exec_d = csl_pkg::PERM_YES;
                if (breakpoint_set)
                begin
                    msl_g = triple;
                    exec_d = csl_pkg::PERM_RESTRICTED;
                end
                else if (ext_fault)
                begin
                    msl_r = single;
                    msl_g = !single;
                end
                else
                begin
                    msl_g = 1'b1;
                end
            end
            csl_pkg::ST_STOP:
            begin
                comm_d = csl_pkg::PERM_RESTRICTED;
                msl_r = ext_error && single;
                msl_g = flash && !(ext_error && single);
            end
            csl_pkg::ST_HALT:
                msl_r = single;
            csl_pkg::ST_REBOOT:
                msl_r = rapid;
            csl_pkg::ST_SYS_HALT:
            begin
                msl_r = 1'b1;
                comm_d = csl_pkg::PERM_NO;
            end
            default:
                comm_d = csl_pkg::PERM_NO;
        endcase
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            module_status_led_green <= 1'b0;
            module_status_led_red <= 1'b0;
            battery_led_red <= 1'b0;
            comm_perm <= csl_pkg::PERM_NO;
            exec_perm <= csl_pkg::PERM_NO;
        end
        else
        begin
            module_status_led_green <= ident ? flash : msl_g;
            module_status_led_red <= ident ? !flash : msl_r;
            battery_led_red <= ident ? flash : pins_s[0];
            comm_perm <= comm_d;
            exec_perm <= exec_d;
        end
    end

    always_ff @(posedge clk or negedge rst_b)
    begin
        if (!rst_b)
        begin
            user_led_zero_green <= 1'b0;
            user_led_zero_red <= 1'b0;
            user_led_one_green <= 1'b0;
            user_led_one_red <= 1'b0;
            power_main_led <= 1'b0;
            power_expert_led <= 1'b0;
            power_io_led <= 1'b0;
        end
        else
        begin
            user_led_zero_green <= ctrl_q[csl_pkg::CTRL_U0_GREEN];
            user_led_zero_red <= ctrl_q[csl_pkg::CTRL_U0_RED];
            user_led_one_green <= ctrl_q[csl_pkg::CTRL_U1_GREEN];
            user_led_one_red <= ctrl_q[csl_pkg::CTRL_U1_RED];
            power_main_led <= pins_s[1];
            power_expert_led <= pins_s[2];
            power_io_led <= pins_s[3];
        end
    end

    // ********************************************************************
    // Assertions
    // ********************************************************************
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_b);

    a_boot_no_exec: assert property (
        st_q == csl_pkg::ST_BOOT |=> comm_perm == csl_pkg::PERM_NO && exec_perm == csl_pkg::PERM_NO)
        else $error("boot state allowed communication or execution");
    a_boot_bad_fw: assert property (
        st_q == csl_pkg::ST_BOOT && boot_done && !fw_valid |=> st_q == csl_pkg::ST_BAD_FW)
        else $error("invalid firmware not detected at boot end");
    a_empty_no_exec: assert property (
        st_q == csl_pkg::ST_EMPTY && !ident |=> !module_status_led_red && exec_perm == csl_pkg::PERM_NO)
        else $error("empty state shows red or executes");
    a_run_steady_green: assert property (
        st_q == csl_pkg::ST_RUN && !breakpoint_set && !ext_fault && !ident
        |=> module_status_led_green && !module_status_led_red)
        else $error("running state not steady green");
    a_app_err_halt: assert property (
        st_q == csl_pkg::ST_RUN && app_error && !hw_error && !sys_error
        |=> st_q == csl_pkg::ST_HALT ##1 exec_perm == csl_pkg::PERM_NO)
        else $error("application error did not halt execution");
    a_sys_halt_red: assert property (
        st_q == csl_pkg::ST_SYS_HALT && !ident |=> module_status_led_red && comm_perm == csl_pkg::PERM_NO)
        else $error("system halt not steady red with communication blocked");
    a_battery_follow: assert property (
        !ident ##1 !ident |-> battery_led_red == $past(pins_s[0]))
        else $error("battery led does not follow battery flag");
    a_user_led_follow: assert property (
        wr_ctrl |=> ##1 user_led_one_red == $past(w_data_q[csl_pkg::CTRL_U1_RED], 2))
        else $error("user led does not follow written value");
    a_power_follow: assert property (
        power_io ##1 power_io ##1 power_io |=> power_io_led)
        else $error("io supply led not lit");
    a_brk_restrict: assert property (
        st_q == csl_pkg::ST_RUN && breakpoint_set |=> exec_perm == csl_pkg::PERM_RESTRICTED)
        else $error("breakpoint did not restrict execution");

    c_reach_run: cover property (st_q == csl_pkg::ST_STOP ##1 st_q == csl_pkg::ST_RUN);
    c_reboot: cover property (st_q == csl_pkg::ST_RUN ##1 st_q == csl_pkg::ST_REBOOT);
    c_identify: cover property (ident && module_status_led_red ##1 module_status_led_green);

endmodule : csl_top

// [bench/tb.sv]
// Self-checking bench for the controller status LED block.
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    localparam int FRAME = 80;
    logic clk, rst_b, boot_done, fw_valid, app_valid, hw_error, app_error, sys_error, ext_error;
    logic boot_proj_bad, breakpoint_set, battery_low, power_main, power_expert, power_io;
    logic s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready, s_axi_bvalid, s_axi_bready;
    logic s_axi_arvalid, s_axi_arready, s_axi_rvalid, s_axi_rready;
    logic [3:0] s_axi_awaddr, s_axi_wstrb, s_axi_araddr;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [1:0] s_axi_bresp, s_axi_rresp, comm_perm, exec_perm;
    logic module_status_led_green, module_status_led_red, battery_led_red, user_led_zero_green;
    logic user_led_zero_red, user_led_one_green, user_led_one_red, power_main_led;
    logic power_expert_led, power_io_led;
    int err_count, n_compared, cyc;

    // One frame is 20 ticks of 4 cycles, so any 80-cycle window holds a whole pattern.
    csl_top #(.TICK_CYCLES(4)) csl_top_inst (.*);

    // ****
    // Bus and check tasks
    // ****
    task automatic chk(input string n, input logic [31:0] s, input logic [31:0] e);
        n_compared++;
        if (s !== e)
        begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", n, e, s);
        end
    endtask : chk

    task automatic tick(input int n);
        repeat (n) @(posedge clk);
    endtask : tick

    task automatic wr(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        logic aw = 1'b0;
        logic w = 1'b0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'b1;
        s_axi_wvalid <= 1'b1;
        s_axi_bready <= 1'b1;
        do
        begin
            @(posedge clk);
            aw = aw | s_axi_awready;
            w = w | s_axi_wready;
            if (aw) s_axi_awvalid <= 1'b0;
            if (w) s_axi_wvalid <= 1'b0;
        end while (s_axi_bvalid !== 1'b1);
        s_axi_bready <= 1'b0;
        chk("bresp", s_axi_bresp, r);
    endtask : wr

    task automatic rd(input logic [3:0] a, input logic [31:0] d, input logic [1:0] r);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'b1;
        s_axi_rready <= 1'b1;
        do @(posedge clk); while (s_axi_arready !== 1'b1);
        s_axi_arvalid <= 1'b0;
        do @(posedge clk); while (s_axi_rvalid !== 1'b1);
        s_axi_rready <= 1'b0;
        chk("rresp", s_axi_rresp, r);
        chk("rdata", s_axi_rdata, d);
    endtask : rd

    task automatic cmd(input logic [31:0] c);
        wr(4'h4, c, 2'h0);
        tick(3);
    endtask : cmd

    task automatic boot(input logic f, input logic a);
        fw_valid <= f;
        app_valid <= a;
        boot_done <= 1'b1;
        tick(1);
        boot_done <= 1'b0;
        tick(3);
    endtask : boot

    task automatic st(input logic [3:0] s, input logic [1:0] c, input logic [1:0] x);
        rd(4'h8, {24'h0, x, c, s}, 2'h0);
        chk("comm_perm", comm_perm, c);
        chk("exec_perm", exec_perm, x);
    endtask : st

    task automatic leds(input string n, input int g, input int r);
        int ng = 0;
        int nr = 0;
        repeat (FRAME)
        begin
            @(posedge clk);
            ng += int'(module_status_led_green === 1'b1);
            nr += int'(module_status_led_red === 1'b1);
        end
        chk("status green", ng, g);
        chk("status red", nr, r);
        $display("%s test done", n);
    endtask : leds

    task automatic give_verdict();
        $display("compared %0d mismatches %0d", n_compared, err_count);
        if (err_count == 0 && n_compared > 0)
            $display("No errors found");
        else
            $display("Errors were found");
        $finish;
    endtask : give_verdict

    initial
    begin
        clk = 1'b0;
        forever #10 clk = ~clk;
    end

    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 20000)
        begin
            err_count++;
            give_verdict();
        end
    end

    // ****
    // Test sequence
    // ****
    initial
    begin
        {boot_done, fw_valid, app_valid, hw_error, app_error, sys_error, ext_error} = 7'h00;
        {boot_proj_bad, breakpoint_set, battery_low, power_main, power_expert, power_io} = 6'h00;
        {s_axi_awvalid, s_axi_wvalid, s_axi_bready, s_axi_arvalid, s_axi_rready} = 5'h00;
        {s_axi_awaddr, s_axi_araddr, s_axi_wdata} = 40'h0;
        s_axi_wstrb = 4'hF;
        rst_b = 1'b0;
        tick(2);
        rst_b <= 1'b1;
        tick(1);
        st(4'h0, 2'h0, 2'h0);
        leds("boot", 40, 40);
        boot(1'b0, 1'b1);
        st(4'h1, 2'h1, 2'h0);
        leds("bad firmware", 0, 40);
        cmd(32'h4);
        boot(1'b1, 1'b0);
        st(4'h2, 2'h2, 2'h0);
        leds("empty", 8, 0);
        cmd(32'h4);
        hw_error <= 1'b1;
        boot(1'b1, 1'b1);
        hw_error <= 1'b0;
        st(4'h2, 2'h2, 2'h0);
        cmd(32'h4);
        boot(1'b1, 1'b1);
        cmd(32'h1);
        st(4'h3, 2'h2, 2'h2);
        leds("run", 80, 0);
        breakpoint_set <= 1'b1;
        tick(3);
        st(4'h3, 2'h2, 2'h1);
        leds("breakpoint", 24, 0);
        breakpoint_set <= 1'b0;
        ext_error <= 1'b1;
        tick(3);
        leds("run external", 72, 8);
        ext_error <= 1'b0;
        boot_proj_bad <= 1'b1;
        tick(3);
        st(4'h3, 2'h2, 2'h2);
        leds("boot project", 72, 8);
        boot_proj_bad <= 1'b0;
        cmd(32'h2);
        st(4'h4, 2'h1, 2'h0);
        leds("stop", 40, 0);
        ext_error <= 1'b1;
        tick(3);
        leds("stop external", 32, 8);
        ext_error <= 1'b0;
        cmd(32'h1);
        app_error <= 1'b1;
        tick(3);
        st(4'h5, 2'h2, 2'h0);
        leds("halt", 0, 8);
        app_error <= 1'b0;
        cmd(32'h2);
        cmd(32'h1);
        hw_error <= 1'b1;
        tick(3);
        st(4'h6, 2'h2, 2'h0);
        leds("reboot", 0, 40);
        hw_error <= 1'b0;
        cmd(32'h4);
        boot(1'b1, 1'b1);
        cmd(32'h1);
        sys_error <= 1'b1;
        tick(3);
        st(4'h7, 2'h0, 2'h0);
        leds("system halt", 0, 80);
        for (int v = 5; v <= 10; v += 5)
        begin
            wr(4'h0, v, 2'h0);
            tick(2);
            chk("user", {user_led_one_red, user_led_one_green, user_led_zero_red, user_led_zero_green}, v);
            rd(4'h0, v, 2'h0);
        end
        wr(4'h0, 32'h10, 2'h0);
        tick(3);
        chk("user", {user_led_one_red, user_led_one_green, user_led_zero_red, user_led_zero_green}, 0);
        leds("identify", 40, 40);
        wr(4'h0, 32'h0, 2'h0);
        for (int i = 0; i < 4; i++)
        begin
            {battery_low, power_io, power_expert, power_main} <= 4'h1 << i;
            tick(4);
            chk("pins", {battery_led_red, power_io_led, power_expert_led, power_main_led}, 4'h1 << i);
        end
        s_axi_wstrb <= 4'h0;
        wr(4'h0, 32'hF, 2'h0);
        s_axi_wstrb <= 4'hF;
        rd(4'h0, 32'h0, 2'h0);
        wr(4'hC, 32'h1, 2'h2);
        rd(4'hC, 32'h0, 2'h2);
        wr(4'h8, 32'h0, 2'h2);
        $display("bus test done");
        give_verdict();
    end
endmodule : tb
